/* hdl/crc_consts.svh */
/*
 Constants for the reset and clock pin control block.
 Assumes inclusion by hdl/crc_pkg.sv and the pin control module.
*/
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH
`define CRC_RESET_VECTOR 20'hFFFF0
`define CRC_NMI_TYPE 8'h02
`define CRC_ADDR_W 20
`define CRC_BUS_W 16
`define CRC_LOW_ADDR_W 16
`define CRC_BYTE_W 8
`define CRC_ZERO16 16'h0000
`define CRC_ZERO8 8'h00
`define CRC_PDT_CLEAR 2'h0
`define CRC_PDT_STEP 2'h1
`define CRC_PDT_SETTLE 2'h2
`endif

/* hdl/crc_pin_ctrl.sv */
/*
 Pin control of an embedded 16-bit processor: output clock divider,
 reset sequencing, numerics mode strap, wait/busy, latched NMI,
 multiplexed bus phasing, per-mode pin states and power-down exit timer.
 Assumes mclk is the doubled input clock and the core supplies bus requests.
 The test-mode strap is sampled here; the testbench resolves tri-state wires.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crc_consts.svh"
module crc_pin_ctrl (
    // Clock, enable, reset
    input wire logic mclk,
    input wire logic ce,
    input wire logic rst_b,
    // External pins
    input wire logic reset_in_n,
    input wire logic nmi_in,
    input wire logic test_busy_in,
    input wire logic upper_mem_select_in,
    input wire logic lower_mem_select_in,
    input wire logic powerdown_exit_timer_pin,
    output logic powerdown_exit_timer_oe_n,
    output logic half_rate_clock_out,
    output logic reset_indication_out,
    output logic crystal_drive_out,
    output logic ale_out,
    output crc_pkg::crc_bus_t muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe_n,
    input wire crc_pkg::crc_bus_t muxed_addr_data_bus_in,
    // Core side
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic byte_wide,
    input wire crc_pkg::crc_addr_t bus_addr,
    input wire crc_pkg::crc_bus_t bus_wdata,
    input wire logic hold_req,
    input wire logic wait_instr,
    input wire logic powerdown_req,
    input wire logic nmi_ack,
    output crc_pkg::crc_bus_t bus_rdata,
    output logic bus_done,
    output crc_pkg::crc_addr_t fetch_addr,
    output logic fetch_start,
    output logic core_stall,
    output logic numerics_mode,
    output logic coproc_busy,
    output logic test_mode,
    output logic nmi_pending,
    output logic [7:0] nmi_type
);
    import crc_pkg::*;

    crc_state_e state_r, state_nxt;
    logic res_s, nmi_s, tb_s, pdt_s;
    logic nmi_prev_r;
    logic in_reset_r;
    logic addr_phase_r;
    logic bus_active_r;
    logic bus_wr_r;
    crc_bus_t wdata_r;
    logic [1:0] pd_wait_r;

    // Synchronised asynchronous inputs: metastability guard
    crc_sync2 u_sync_res (.mclk(mclk), .rst_b(rst_b), .ce(ce), .d(reset_in_n), .q(res_s));
    crc_sync2 u_sync_nmi (.mclk(mclk), .rst_b(rst_b), .ce(ce), .d(nmi_in), .q(nmi_s));
    crc_sync2 u_sync_tb (.mclk(mclk), .rst_b(rst_b), .ce(ce), .d(test_busy_in), .q(tb_s));
    crc_sync2 u_sync_pdt (.mclk(mclk), .rst_b(rst_b), .ce(ce),
        .d(powerdown_exit_timer_pin), .q(pdt_s));

    // Decode
    wire reset_now = !res_s;
    wire reset_rise = in_reset_r && res_s;
    wire nmi_edge = nmi_s && !nmi_prev_r;
    wire in_pd = (state_r == CRC_POWERDOWN) || (state_r == CRC_PD_EXIT);
    wire run_ok = (state_r == CRC_RUN);
    wire start_cycle = run_ok && bus_req && !bus_active_r && !hold_req;
    wire test_released = !tb_s;
    wire [15:0] addr_lo = byte_wide ? {`CRC_ZERO8, bus_addr[`CRC_BYTE_W-1:0]}
                                    : bus_addr[`CRC_LOW_ADDR_W-1:0];
    wire [15:0] data_out = byte_wide ? {`CRC_ZERO8, wdata_r[`CRC_BYTE_W-1:0]} : wdata_r;
    wire bus_float = in_reset_r || test_mode || (hold_req && !in_pd);
    // Synchroniser still shows the driven level for two cycles after release
    wire pd_settled = (pd_wait_r == `CRC_PDT_SETTLE);
    wire [1:0] pd_wait_nxt = (state_r != CRC_PD_EXIT) ? `CRC_PDT_CLEAR
        : (pd_settled ? pd_wait_r : pd_wait_r + `CRC_PDT_STEP);

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CRC_RESET: state_nxt = reset_rise ? CRC_REALIGN : CRC_RESET;
            CRC_REALIGN: state_nxt = CRC_RUN;
            CRC_RUN: begin
                if (powerdown_req && !bus_active_r)
                    state_nxt = CRC_POWERDOWN;
                else if (wait_instr && !numerics_mode)
                    state_nxt = CRC_WAIT_TEST;
            end
            CRC_WAIT_TEST: state_nxt = test_released ? CRC_RUN : CRC_WAIT_TEST;
            CRC_POWERDOWN: state_nxt = (nmi_edge || nmi_pending) ? CRC_PD_EXIT : CRC_POWERDOWN;
            CRC_PD_EXIT: state_nxt = (pdt_s && pd_settled) ? CRC_RUN : CRC_PD_EXIT;
            default: state_nxt = CRC_RESET;
        endcase
        if (reset_now)
            state_nxt = CRC_RESET;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= CRC_RESET;
            in_reset_r <= 1'b1;
            nmi_prev_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            in_reset_r <= reset_now;
            nmi_prev_r <= nmi_s;
        end
    end

    // Output clock divider, realigned at reset release
    always_ff @(negedge mclk or negedge rst_b) begin
        if (!rst_b)
            half_rate_clock_out <= 1'b0;
        else if (ce) begin
            if (state_r == CRC_REALIGN || in_reset_r)
                half_rate_clock_out <= 1'b0;
            else
                half_rate_clock_out <= !half_rate_clock_out;
        end
    end

    // Reset output and straps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reset_indication_out <= 1'b1;
            numerics_mode <= 1'b0;
            test_mode <= 1'b0;
        end else if (ce) begin
            reset_indication_out <= reset_now;
            if (reset_now) begin
                numerics_mode <= tb_s;
                test_mode <= !upper_mem_select_in && !lower_mem_select_in;
            end
        end
    end

    // Busy seen only in numerics mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            coproc_busy <= 1'b0;
        else if (ce)
            coproc_busy <= numerics_mode && !reset_now && tb_s;
    end

    // NMI latch: a new edge wins over the acknowledge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nmi_pending <= 1'b0;
            nmi_type <= `CRC_ZERO8;
        end else if (ce) begin
            nmi_type <= `CRC_NMI_TYPE;
            if (reset_now)
                nmi_pending <= 1'b0;
            else if (nmi_edge)
                nmi_pending <= 1'b1;
            else if (nmi_ack)
                nmi_pending <= 1'b0;
        end
    end

    // Fetch vector after realign
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_addr <= `CRC_RESET_VECTOR;
            fetch_start <= 1'b0;
            core_stall <= 1'b1;
        end else if (ce) begin
            fetch_addr <= `CRC_RESET_VECTOR;
            fetch_start <= (state_r == CRC_REALIGN) && !reset_now;
            core_stall <= !(state_nxt == CRC_RUN) || coproc_busy;
        end
    end

    // Bus cycle: one address cycle then one data cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus_active_r <= 1'b0;
            addr_phase_r <= 1'b0;
            bus_wr_r <= 1'b0;
            wdata_r <= `CRC_ZERO16;
            ale_out <= 1'b0;
            bus_done <= 1'b0;
            bus_rdata <= `CRC_ZERO16;
            muxed_addr_data_bus_out <= `CRC_ZERO16;
            muxed_addr_data_bus_oe_n <= 1'b1;
        end else if (ce) begin
            bus_done <= 1'b0;
            ale_out <= 1'b0;
            if (reset_now) begin
                bus_active_r <= 1'b0;
                addr_phase_r <= 1'b0;
                muxed_addr_data_bus_oe_n <= 1'b1;
            end else if (in_pd) begin
                muxed_addr_data_bus_oe_n <= muxed_addr_data_bus_oe_n;
            end else if (start_cycle) begin
                bus_active_r <= 1'b1;
                addr_phase_r <= 1'b1;
                bus_wr_r <= bus_write;
                wdata_r <= bus_wdata;
                ale_out <= 1'b1;
                muxed_addr_data_bus_out <= addr_lo;
                muxed_addr_data_bus_oe_n <= bus_float;
            end else if (addr_phase_r) begin
                addr_phase_r <= 1'b0;
                muxed_addr_data_bus_out <= bus_wr_r ? data_out : `CRC_ZERO16;
                muxed_addr_data_bus_oe_n <= bus_float || !bus_wr_r;
            end else if (bus_active_r) begin
                bus_active_r <= 1'b0;
                bus_done <= 1'b1;
                bus_rdata <= byte_wide ?
                    {`CRC_ZERO8, muxed_addr_data_bus_in[`CRC_BYTE_W-1:0]}
                    : muxed_addr_data_bus_in;
                muxed_addr_data_bus_oe_n <= 1'b1;
            end else begin
                muxed_addr_data_bus_oe_n <= 1'b1;
            end
        end
    end

    // Timer pin: driven high in power-down unless test mode is strapped, released otherwise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            powerdown_exit_timer_oe_n <= 1'b1;
            crystal_drive_out <= 1'b0;
        end else if (ce) begin
            powerdown_exit_timer_oe_n <= !(state_nxt == CRC_POWERDOWN) || reset_now
                || test_mode;
            crystal_drive_out <= !crystal_drive_out;
        end
    end

    // Settle count: a stale high from the driven phase must not end the wait
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            pd_wait_r <= `CRC_PDT_CLEAR;
        else if (ce)
            pd_wait_r <= pd_wait_nxt;
    end

    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b || !ce);

    reset_out_follow_a: assert property (!res_s |=> reset_indication_out)
        else $error("reset output not asserted during reset");
    reset_abort_a: assert property (!res_s |=> !bus_active_r)
        else $error("bus cycle survived reset");
    bus_float_a: assert property (in_reset_r |-> muxed_addr_data_bus_oe_n)
        else $error("bus driven during reset");
    fetch_after_a: assert property ($rose(fetch_start) |-> $past(state_r) == CRC_REALIGN)
        else $error("fetch start without realign");
    fetch_vec_a: assert property (fetch_start |-> fetch_addr == `CRC_RESET_VECTOR)
        else $error("wrong fetch address");
    nmi_latch_a: assert property (nmi_edge && res_s |=> nmi_pending && nmi_type == `CRC_NMI_TYPE)
        else $error("nmi edge not latched");
    wait_hold_a: assert property (state_r == CRC_WAIT_TEST && tb_s && res_s
        |=> state_r == CRC_WAIT_TEST)
        else $error("wait released while test high");
    ale_addr_a: assert property (ale_out |-> ##1 !ale_out)
        else $error("address strobe longer than one cycle");
    pd_exit_a: assert property (state_r == CRC_PD_EXIT && !pdt_s && res_s
        |=> state_r == CRC_PD_EXIT)
        else $error("power-down exit before timer");
    busy_mode_a: assert property (coproc_busy |-> numerics_mode)
        else $error("busy outside numerics mode");
    crystal_run_a: assert property (crystal_drive_out |=> !crystal_drive_out)
        else $error("crystal drive stuck");
    hold_float_a: assert property (hold_req && !in_pd |=> muxed_addr_data_bus_oe_n)
        else $error("bus driven during hold");
    test_float_a: assert property (test_mode |-> muxed_addr_data_bus_oe_n && powerdown_exit_timer_oe_n)
        else $error("pin driven in test mode");
    pd_settle_a: assert property (state_r == CRC_PD_EXIT && !pd_settled && res_s
        |=> state_r == CRC_PD_EXIT)
        else $error("power-down exit before settle");

    cov_reset_c: cover property (reset_rise ##2 fetch_start);
    cov_bus_c: cover property (start_cycle ##2 bus_done);
    cov_wait_c: cover property (state_r == CRC_WAIT_TEST ##1 state_r == CRC_RUN);
    cov_pd_c: cover property (state_r == CRC_PD_EXIT ##1 state_r == CRC_RUN);
    cov_hold_c: cover property (hold_req && bus_req ##1 !ale_out);
endmodule
`default_nettype wire

/* hdl/crc_pkg.sv */
/*
 Types for the reset and clock pin control block.
 Assumes hdl/crc_consts.svh on the include path.
*/
`include "crc_consts.svh"
package crc_pkg;
    typedef enum logic [2:0] {
        CRC_RESET,
        CRC_REALIGN,
        CRC_RUN,
        CRC_WAIT_TEST,
        CRC_POWERDOWN,
        CRC_PD_EXIT
    } crc_state_e;
    typedef logic [`CRC_BUS_W-1:0] crc_bus_t;
    typedef logic [`CRC_ADDR_W-1:0] crc_addr_t;
endpackage

/* hdl/crc_sync2.sv */
/*
 Two-stage synchroniser for asynchronous pin inputs.
 Assumes a single clock domain; first stage is read only by the second.
*/
`timescale 1ns/10ps
`default_nettype none
module crc_sync2 (
    // Clock, enable and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // Data
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* test/crc_far_model.sv */
/*
 Far-side model: memory answering reads and a coprocessor on the busy pin.
 Assumes the bench sets coprocessor presence and the test pin level.
*/
`timescale 1ns/10ps
`default_nettype none
module crc_far_model (
    // Bus side
    input wire logic mclk,
    input wire logic ale_out,
    input wire crc_pkg::crc_bus_t bus_out,
    input wire logic bus_oe_n,
    output crc_pkg::crc_bus_t bus_in,
    // Coprocessor side
    input wire logic copro_present,
    input wire logic reset_ind,
    input wire logic busy_lvl,
    output logic test_busy
);
    import crc_pkg::*;
    crc_bus_t addr_r;
    always_ff @(posedge mclk) begin
        if (ale_out) begin
            addr_r <= bus_out;
        end
    end
    // Released bus shows read data, never a stale copy of the address
    assign bus_in = bus_oe_n ? (addr_r ^ 16'h5AC3) : ~bus_out;
    // Busy pin held high while the reset output is asserted, when fitted; otherwise it follows busy_lvl
    assign test_busy = (copro_present && reset_ind) ? 1'b1 : busy_lvl;
endmodule
`default_nettype wire

/* test/tb_cpu_reset_clock_pin_control.sv */
/*
 Self-checking bench for the pin control block.
 Assumes crc_pkg and the far-side model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_reset_clock_pin_control;
    import crc_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, reset_in_n = 1'b0, nmi_in = 1'b0, ums = 1'b1, lms = 1'b1;
    logic pd_pin = 1'b0, bus_req = 1'b0, bus_write = 1'b0, byte_wide = 1'b0, wait_instr = 1'b0;
    logic pd_req = 1'b0, nmi_ack = 1'b0, copro = 1'b0, busy_lvl = 1'b0, hold = 1'b0;
    logic pd_oe_n, hclk, rst_ind, xtal, ale, bus_oe_n, test_busy, bus_done, fetch_start;
    logic core_stall, num_mode, cp_busy, tmode, nmi_pend, pd_wire;
    logic [7:0] nmi_type;
    crc_addr_t bus_addr = 20'h00000;
    crc_addr_t fetch_addr;
    crc_bus_t bus_wdata = 16'h0000;
    crc_bus_t bus_out, bus_in, bus_rdata;
    int failures = 0, cmp_count = 0;

    always #12.5 mclk = ~mclk;
    // Timer pin is pulled up only by the device while it drives
    assign pd_wire = pd_oe_n ? pd_pin : 1'b1;

    crc_pin_ctrl crc_pin_ctrl_i (.mclk(mclk), .ce(1'b1), .rst_b(rst_b), .reset_in_n(reset_in_n),
        .nmi_in(nmi_in), .test_busy_in(test_busy), .upper_mem_select_in(ums),
        .lower_mem_select_in(lms), .powerdown_exit_timer_pin(pd_wire),
        .powerdown_exit_timer_oe_n(pd_oe_n), .half_rate_clock_out(hclk),
        .reset_indication_out(rst_ind), .crystal_drive_out(xtal), .ale_out(ale),
        .muxed_addr_data_bus_out(bus_out), .muxed_addr_data_bus_oe_n(bus_oe_n),
        .muxed_addr_data_bus_in(bus_in), .bus_req(bus_req), .bus_write(bus_write),
        .byte_wide(byte_wide), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .hold_req(hold),
        .wait_instr(wait_instr), .powerdown_req(pd_req), .nmi_ack(nmi_ack),
        .bus_rdata(bus_rdata), .bus_done(bus_done), .fetch_addr(fetch_addr),
        .fetch_start(fetch_start), .core_stall(core_stall), .numerics_mode(num_mode),
        .coproc_busy(cp_busy), .test_mode(tmode), .nmi_pending(nmi_pend), .nmi_type(nmi_type));

    crc_far_model crc_far_model_i (.mclk(mclk), .ale_out(ale), .bus_out(bus_out),
        .bus_oe_n(bus_oe_n), .bus_in(bus_in), .copro_present(copro), .reset_ind(rst_ind),
        .busy_lvl(busy_lvl), .test_busy(test_busy));

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic t_reset;
        int n;
        n = 0;
        cyc(2);
        rst_b = 1'b1;
        cyc(3);
        chk("rst_ind", 20'h00001, 20'(rst_ind));
        chk("bus_oe_n", 20'h00001, 20'(bus_oe_n));
        chk("fetch_addr", 20'hFFFF0, fetch_addr);
        reset_in_n = 1'b1;
        repeat (10) begin
            cyc(1);
            n += int'(fetch_start);
        end
        chk("fetch_pulses", 20'h00001, 20'(n));
        chk("rst_ind", 20'h00000, 20'(rst_ind));
        chk("num_mode", 20'h00000, 20'(num_mode));
        // Test pin idles high on_circuit_test_mode regular mode is strapped
        busy_lvl = 1'b1;
    endtask

    task automatic t_clk;
        logic v, x;
        // Read after the falling-edge update has landed
        #2;
        v = hclk;
        x = xtal;
        repeat (4) begin
            cyc(1);
            #2;
            chk("hclk", 20'(!v), 20'(hclk));
            chk("xtal", 20'(!x), 20'(xtal));
            v = hclk;
            x = xtal;
        end
        cyc(1);
    endtask

    task automatic t_bus(input logic wr, input logic bw, input crc_addr_t a, input crc_bus_t d);
        int n;
        bus_write = wr;
        byte_wide = bw;
        bus_addr = a;
        bus_wdata = d;
        bus_req = 1'b1;
        cyc(1);
        bus_req = 1'b0;
        chk("ale", 20'h00001, 20'(ale));
        chk("addr", bw ? 20'(a[7:0]) : 20'(a[15:0]), 20'(bus_out));
        chk("oe_addr", 20'h00000, 20'(bus_oe_n));
        cyc(1);
        chk("oe_data", 20'(!wr), 20'(bus_oe_n));
        if (wr) begin
            chk("wdata", bw ? 20'(d[7:0]) : 20'(d), 20'(bus_out));
        end
        for (n = 0; n < 4 && bus_done !== 1'b1; n++) begin
            cyc(1);
        end
        chk("done", 20'h00001, 20'(bus_done));
        if (!wr) begin
            chk("rdata", 20'(a[15:0] ^ 16'h5AC3), 20'(bus_rdata));
        end
    endtask

    task automatic t_hold;
        int n;
        n = 0;
        hold = 1'b1;
        bus_write = 1'b1;
        bus_req = 1'b1;
        repeat (4) begin
            cyc(1);
            n += int'(ale) + int'(!bus_oe_n);
        end
        chk("hold_idle", 20'h00000, 20'(n));
        hold = 1'b0;
        cyc(1);
        bus_req = 1'b0;
        chk("ale_after_hold", 20'h00001, 20'(ale));
        hold = 1'b1;
        cyc(1);
        chk("oe_hold_data", 20'h00001, 20'(bus_oe_n));
        hold = 1'b0;
        cyc(2);
    endtask

    task automatic t_nmi;
        nmi_in = 1'b1;
        cyc(5);
        chk("nmi_pend", 20'h00001, 20'(nmi_pend));
        chk("nmi_type", 20'h00002, 20'(nmi_type));
        nmi_ack = 1'b1;
        cyc(1);
        nmi_ack = 1'b0;
        cyc(2);
        // Pin still high: only an edge may set it again
        chk("nmi_pend", 20'h00000, 20'(nmi_pend));
        nmi_in = 1'b0;
        cyc(3);
    endtask

    task automatic t_wait;
        wait_instr = 1'b1;
        cyc(1);
        wait_instr = 1'b0;
        cyc(4);
        chk("stall", 20'h00001, 20'(core_stall));
        busy_lvl = 1'b0;
        cyc(5);
        chk("stall", 20'h00000, 20'(core_stall));
        busy_lvl = 1'b1;
    endtask

    task automatic t_pd;
        int n;
        n = 0;
        pd_req = 1'b1;
        cyc(1);
        pd_req = 1'b0;
        cyc(2);
        chk("pd_oe_n", 20'h00000, 20'(pd_oe_n));
        chk("bus_oe_n", 20'h00001, 20'(bus_oe_n));
        nmi_in = 1'b1;
        bus_write = 1'b0;
        bus_req = 1'b1;
        repeat (8) begin
            cyc(1);
            n += int'(ale);
        end
        chk("ale_in_exit", 20'h00000, 20'(n));
        bus_req = 1'b0;
        pd_pin = 1'b1;
        nmi_in = 1'b0;
        cyc(6);
        chk("pd_oe_exit", 20'h00001, 20'(pd_oe_n));
        nmi_ack = 1'b1;
        cyc(1);
        nmi_ack = 1'b0;
        t_bus(1'b0, 1'b0, 20'h0ABCD, 16'h0000);
    endtask

    task automatic t_num;
        int n;
        copro = 1'b1;
        busy_lvl = 1'b0;
        ums = 1'b0;
        lms = 1'b0;
        // Reset lands in the middle of a read cycle
        bus_write = 1'b0;
        bus_req = 1'b1;
        reset_in_n = 1'b0;
        cyc(1);
        bus_req = 1'b0;
        chk("ale_abort", 20'h00001, 20'(ale));
        n = 0;
        repeat (4) begin
            cyc(1);
            n += int'(bus_done);
        end
        chk("done_abort", 20'h00000, 20'(n));
        chk("rst_ind", 20'h00001, 20'(rst_ind));
        chk("bus_oe_n", 20'h00001, 20'(bus_oe_n));
        reset_in_n = 1'b1;
        cyc(8);
        chk("num_mode", 20'h00001, 20'(num_mode));
        chk("test_mode", 20'h00001, 20'(tmode));
        busy_lvl = 1'b1;
        cyc(4);
        chk("cp_busy", 20'h00001, 20'(cp_busy));
        bus_req = 1'b1;
        cyc(1);
        bus_req = 1'b0;
        chk("oe_test", 20'h00001, 20'(bus_oe_n));
        busy_lvl = 1'b0;
        cyc(4);
        chk("cp_busy", 20'h00000, 20'(cp_busy));
    endtask

    task automatic end_sim;
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is about a hundred cycles; generous margin
    initial begin
        #50000;
        failures++;
        end_sim();
    end

    initial begin
        t_reset();
        t_clk();
        t_bus(1'b1, 1'b0, 20'h5A5A5, 16'hC3A1);
        t_bus(1'b1, 1'b1, 20'h0FF0F, 16'hBEEF);
        t_bus(1'b0, 1'b0, 20'h12345, 16'h0000);
        t_hold();
        t_nmi();
        t_wait();
        t_pd();
        t_num();
        end_sim();
    end
endmodule
`default_nettype wire
